// ---- hvt_consts.svh ----
// offsets, field positions, reset values and class codes of the hypervisor trap controls
`ifndef HVT_CONSTS_SVH
`define HVT_CONSTS_SVH
// ==========================================================
// register byte offsets
`define HVT_OFS_CFG_LO     8'h00
`define HVT_OFS_CFG_HI     8'h04
`define HVT_OFS_DBG_CFG    8'h08
`define HVT_OFS_GUEST_CTL  8'h0C
`define HVT_OFS_STATUS     8'h10
// ==========================================================
// hypervisor_config field positions (64-bit register)
`define HVT_BIT_GEN_TRAP   27
`define HVT_BIT_VM_WTRAP   26
`define HVT_BIT_TLB_TRAP   25
`define HVT_BIT_FIQ_ROUTE  3
`define HVT_BIT_IRQ_ROUTE  4
`define HVT_BIT_ABT_ROUTE  5
`define HVT_BIT_HOST_EXT   34
// hyp_debug_config field positions
`define HVT_BIT_DBG_ROM    0
`define HVT_BIT_DBG_OS     1
`define HVT_BIT_DBG_ACC    2
`define HVT_BIT_DBG_EXC    3
// guest control: stage-one translation enable
`define HVT_BIT_STAGE1     0
// ==========================================================
// reset values
`define HVT_RST_CFG        64'h0000_0000_0000_0000
`define HVT_RST_DBG        4'h0
`define HVT_RST_GUEST      1'b0
// ==========================================================
// exception class codes
`define HVT_EC_SYSREG64    6'h18
`define HVT_EC_COPROC_ONE  6'h03
`define HVT_EC_COPROC_TWO  6'h04
`endif

// ---- hvt_pkg.sv ----
// types shared by the hypervisor trap control block
package hvt_pkg;
  // ========================================================
  // privilege levels
  typedef enum logic [1:0] {
    HVT_USER_LEVEL   = 2'b00,
    HVT_GUEST_LEVEL  = 2'b01,
    HVT_HYP_LEVEL    = 2'b10,
    HVT_TOP_LEVEL    = 2'b11
  } hvt_level_e;
  // ========================================================
  // operations offered for checking
  typedef enum logic [3:0] {
    HVT_OP_SYSREG_WR64   = 4'h0,
    HVT_OP_COPROC_SINGLE = 4'h1,
    HVT_OP_COPROC_DOUBLE = 4'h2,
    HVT_OP_TLBI64_LOCAL  = 4'h3,
    HVT_OP_TLBI64_IS     = 4'h4,
    HVT_OP_TLBI64_OS     = 4'h5,
    HVT_OP_TLBI64_RANGE  = 4'h6,
    HVT_OP_TLBI64_RNG_OS = 4'h7,
    HVT_OP_TLBI32        = 4'h8,
    HVT_OP_EXC_RETURN    = 4'h9
  } hvt_op_e;
  // ========================================================
  typedef struct packed {
    logic       valid;
    hvt_op_e    op;
    hvt_level_e level;
    hvt_level_e target;
    logic       guest_32;
  } hvt_req_s;
  typedef struct packed {
    logic       trap;
    logic       undef;
    logic       illegal_ret;
    logic [5:0] exception_class;
  } hvt_resp_s;
  typedef struct packed {
    logic [63:0] hypervisor_config;
    logic [3:0]  hyp_debug_config;
    logic        guest_stage1_enable;
    logic [31:0] rdata;
    hvt_resp_s   resp;
    logic        resp_valid;
    logic [15:0] trap_count;
  } hvt_state_s;
endpackage : hvt_pkg

// ---- hvt_eff_field.sv ----
// one control bit with its effective value under a forced override
`timescale 1ns/1ns
module hvt_eff_field (
  input  wire logic stored_i,
  input  wire logic force_i,
  input  wire logic force_val_i,
  output logic      eff_o
);
  // evaluated from the live register on every use; never held in a cache
  assign eff_o = force_i ? force_val_i : stored_i;
endmodule : hvt_eff_field

// ---- hvt_trap_decode.sv ----
// decides trap, undefined or illegal return for one offered operation
`timescale 1ns/1ns
module hvt_trap_decode
  import hvt_pkg::*;
#(
  parameter bit OS_TLBI_IMPL    = 1'b1,
  parameter bit RANGE_TLBI_IMPL = 1'b1
) (
  input  hvt_req_s  req_i,
  input  wire logic vm_trap_en_i,
  input  wire logic tlb_trap_en_i,
  input  wire logic ret_block_i,
  output hvt_resp_s resp_o
);
  `include "hvt_consts.svh"
  logic guest;
  logic user;
  logic tlbi64;
  logic known;
  assign guest = (req_i.level == HVT_GUEST_LEVEL);
  assign user  = (req_i.level == HVT_USER_LEVEL);
  always_comb begin
    tlbi64 = 1'b0;
    known  = 1'b1;
    case (req_i.op)
      HVT_OP_TLBI64_LOCAL,
      HVT_OP_TLBI64_IS:     tlbi64 = 1'b1;
      HVT_OP_TLBI64_OS:     begin
        tlbi64 = OS_TLBI_IMPL;
        known  = OS_TLBI_IMPL;
      end
      HVT_OP_TLBI64_RANGE:  begin
        tlbi64 = RANGE_TLBI_IMPL;
        known  = RANGE_TLBI_IMPL;
      end
      HVT_OP_TLBI64_RNG_OS: begin
        tlbi64 = OS_TLBI_IMPL & RANGE_TLBI_IMPL;
        known  = OS_TLBI_IMPL & RANGE_TLBI_IMPL;
      end
      default:              tlbi64 = 1'b0;
    endcase
  end
  always_comb begin
    resp_o = '0;
    if (req_i.valid) begin
      case (req_i.op)
        HVT_OP_SYSREG_WR64: begin
          if (guest && !req_i.guest_32 && vm_trap_en_i) begin
            resp_o.trap            = 1'b1;
            resp_o.exception_class = `HVT_EC_SYSREG64;
          end
        end
        HVT_OP_COPROC_SINGLE: begin
          if (guest && req_i.guest_32 && vm_trap_en_i) begin
            resp_o.trap            = 1'b1;
            resp_o.exception_class = `HVT_EC_COPROC_ONE;
          end
        end
        HVT_OP_COPROC_DOUBLE: begin
          if (guest && req_i.guest_32 && vm_trap_en_i) begin
            resp_o.trap            = 1'b1;
            resp_o.exception_class = `HVT_EC_COPROC_TWO;
          end
        end
        HVT_OP_TLBI32: begin
          if (user) begin
            resp_o.undef = 1'b1;
          end else if (guest && req_i.guest_32 && tlb_trap_en_i) begin
            resp_o.trap            = 1'b1;
            resp_o.exception_class = `HVT_EC_COPROC_ONE;
          end
        end
        HVT_OP_EXC_RETURN: begin
          resp_o.illegal_ret = ret_block_i && (req_i.target == HVT_GUEST_LEVEL);
        end
        default: begin
          if (user || !known) begin
            resp_o.undef = 1'b1;
          end else if (guest && !req_i.guest_32 && tlbi64 && tlb_trap_en_i) begin
            resp_o.trap            = 1'b1;
            resp_o.exception_class = `HVT_EC_SYSREG64;
          end
        end
      endcase
    end
  end
endmodule : hvt_trap_decode

// ---- hvt_trap_ctrl.sv ----
// hypervisor trap controls: configuration registers, effective values and trap decisions
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module hvt_trap_ctrl
  import hvt_pkg::*;
#(
  parameter int ADDR_W          = 8,
  parameter bit OS_TLBI_IMPL    = 1'b1,
  parameter bit RANGE_TLBI_IMPL = 1'b1
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // processor context
  input  wire logic        hyp_enabled_i,
  input  wire logic        exc_to_guest_i,
  // operation check
  input  hvt_req_s         req_i,
  output logic             commit_ok_o,
  output logic             resp_valid_o,
  output hvt_resp_s        resp_o,
  // effective controls
  output logic             route_exc_to_hyp_o,
  output logic             eff_stage1_enable_o,
  output logic             virq_enable_o,
  output logic [3:0]       eff_debug_o,
  output logic [2:0]       eff_route_o,
  output logic             host_support_o
);
  `include "hvt_consts.svh"
  // ==========================================================
  // parameter check, refused at elaboration so a bad map never reaches simulation
  if (ADDR_W < 5) begin : g_addr_w_check
    $error("hvt_trap_ctrl: ADDR_W too small for the register map");
  end
  // ==========================================================
  // state
  hvt_state_s state;
  hvt_state_s next_state;
  logic       gen_trap;
  logic       host_ext;
  logic       gen_active;
  logic       vm_trap_en;
  logic       tlb_trap_en;
  logic [3:0] dbg_stored;
  logic [2:0] route_stored;
  hvt_resp_s  dec_resp;
  logic [7:0] ofs;
  assign ofs        = 8'(addr_i);
  assign gen_trap   = state.hypervisor_config[`HVT_BIT_GEN_TRAP];
  assign host_ext   = state.hypervisor_config[`HVT_BIT_HOST_EXT];
  // only counts where the hypervisor level is enabled
  assign gen_active = gen_trap && hyp_enabled_i;
  // general trap masks the two finer traps for every purpose but a read
  assign vm_trap_en  = hyp_enabled_i && !gen_trap && state.hypervisor_config[`HVT_BIT_VM_WTRAP];
  assign tlb_trap_en = hyp_enabled_i && !gen_trap && state.hypervisor_config[`HVT_BIT_TLB_TRAP];
  // ==========================================================
  // effective values
  assign route_exc_to_hyp_o  = gen_active && exc_to_guest_i;
  assign eff_stage1_enable_o = state.guest_stage1_enable && !gen_active;
  assign virq_enable_o       = !gen_active;
  assign host_support_o      = host_ext;
  assign dbg_stored   = state.hyp_debug_config;
  assign route_stored = {state.hypervisor_config[`HVT_BIT_ABT_ROUTE],
                         state.hypervisor_config[`HVT_BIT_IRQ_ROUTE],
                         state.hypervisor_config[`HVT_BIT_FIQ_ROUTE]};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_dbg
      hvt_eff_field u_dbg (
        .stored_i    (dbg_stored[gi]),
        .force_i     (gen_active),
        .force_val_i (1'b1),
        .eff_o       (eff_debug_o[gi])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_route
      // effective routing follows the bit alone, as the hypervisor-enable gate is not stated for it
      hvt_eff_field u_route (
        .stored_i    (route_stored[gi]),
        .force_i     (gen_trap),
        .force_val_i (!host_ext),
        .eff_o       (eff_route_o[gi])
      );
    end
  endgenerate
  // ==========================================================
  // trap decision
  hvt_trap_decode #(
    .OS_TLBI_IMPL    (OS_TLBI_IMPL),
    .RANGE_TLBI_IMPL (RANGE_TLBI_IMPL)
  ) u_decode (
    .req_i         (req_i),
    .vm_trap_en_i  (vm_trap_en),
    .tlb_trap_en_i (tlb_trap_en),
    .ret_block_i   (gen_active),
    .resp_o        (dec_resp)
  );
  // the commit gate is combinational so a trapped operation is stopped before it retires
  assign commit_ok_o = req_i.valid && !dec_resp.trap && !dec_resp.undef && !dec_resp.illegal_ret;
  // ==========================================================
  // next state
  always_comb begin
    next_state            = state;
    next_state.rdata      = 32'h0000_0000;
    next_state.resp_valid = req_i.valid;
    next_state.resp       = dec_resp;
    if (dec_resp.trap && (state.trap_count != 16'hFFFF)) begin
      next_state.trap_count = state.trap_count + 16'h0001;
    end
    // a guest write to stage-one enable lands only when not trapped
    if (commit_ok_o && (req_i.op == HVT_OP_SYSREG_WR64) && req_i.level == HVT_GUEST_LEVEL) begin
      next_state.guest_stage1_enable = 1'b1;
    end
    if (wr_i) begin
      if (ofs == `HVT_OFS_CFG_LO) begin
        next_state.hypervisor_config[31:0] = wdata_i;
      end else if (ofs == `HVT_OFS_CFG_HI) begin
        next_state.hypervisor_config[63:32] = wdata_i;
      end else if (ofs == `HVT_OFS_DBG_CFG) begin
        next_state.hyp_debug_config = wdata_i[3:0];
      end else if (ofs == `HVT_OFS_GUEST_CTL) begin
        next_state.guest_stage1_enable = wdata_i[`HVT_BIT_STAGE1];
      end else if (ofs == `HVT_OFS_STATUS) begin
        next_state.trap_count = 16'h0000;
      end
    end
    if (rd_i) begin
      // direct reads return stored values, never the forced ones
      if (ofs == `HVT_OFS_CFG_LO) begin
        next_state.rdata = state.hypervisor_config[31:0];
      end else if (ofs == `HVT_OFS_CFG_HI) begin
        next_state.rdata = state.hypervisor_config[63:32];
      end else if (ofs == `HVT_OFS_DBG_CFG) begin
        next_state.rdata = {28'h0000000, state.hyp_debug_config};
      end else if (ofs == `HVT_OFS_GUEST_CTL) begin
        next_state.rdata = {31'h00000000, state.guest_stage1_enable};
      end else if (ofs == `HVT_OFS_STATUS) begin
        next_state.rdata = {state.trap_count, 6'h00, gen_active, host_ext,
                            2'b00, state.resp.exception_class};
      end else begin
        next_state.rdata = 32'h0000_0000;
      end
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      // architecturally any value is allowed; zero is chosen so simulation starts defined
      state.hypervisor_config   <= `HVT_RST_CFG;
      state.hyp_debug_config    <= `HVT_RST_DBG;
      state.guest_stage1_enable <= `HVT_RST_GUEST;
      state.rdata               <= 32'h0000_0000;
      state.resp                <= '0;
      state.resp_valid          <= 1'b0;
      state.trap_count          <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end
  assign rdata_o      = state.rdata;
  assign resp_o       = state.resp;
  assign resp_valid_o = state.resp_valid;
endmodule : hvt_trap_ctrl

// ---- hvt_trap_ctrl_assertions.sv ----
// concurrent checks on the ports of the hypervisor trap control block
`timescale 1ns/1ns
module hvt_trap_ctrl_chk
  import hvt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              hyp_enabled_i,
  input  wire logic              exc_to_guest_i,
  input  hvt_req_s               req_i,
  input  wire logic              commit_ok_o,
  input  wire logic              resp_valid_o,
  input  hvt_resp_s              resp_o,
  input  wire logic              route_exc_to_hyp_o,
  input  wire logic              eff_stage1_enable_o,
  input  wire logic              virq_enable_o,
  input  wire logic [3:0]        eff_debug_o,
  input  wire logic [2:0]        eff_route_o,
  input  wire logic              host_support_o
);
  // ==========================================================
  // shadow of the stored control bits, rebuilt from bus writes
  logic [31:0] lo;
  logic        hx;
  logic        gh;
  assign gh = lo[27] && hyp_enabled_i;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lo <= '0;
      hx <= 1'b0;
    end else begin
      if (wr_i && addr_i == ADDR_W'(8'h00)) lo <= wdata_i;
      if (wr_i && addr_i == ADDR_W'(8'h04)) hx <= wdata_i[2];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ==========================================================
  sequence s_vm_req;
    req_i.valid && req_i.op == HVT_OP_SYSREG_WR64 && req_i.level == HVT_GUEST_LEVEL && !req_i.guest_32;
  endsequence
  sequence s_trap18;
    resp_valid_o && resp_o.trap && resp_o.exception_class == 6'h18;
  endsequence
  a_user_unaffected: assert property (!gh |-> virq_enable_o && !route_exc_to_hyp_o)
    else $error("user level affected without hypervisor routing");
  a_route_to_hyp: assert property (route_exc_to_hyp_o == (gh && exc_to_guest_i))
    else $error("guest exception routing wrong");
  a_stage1_forced: assert property (gh |-> !eff_stage1_enable_o)
    else $error("stage one enable not forced off");
  a_virq_off: assert property (virq_enable_o == !gh)
    else $error("virtual interrupt enable wrong");
  a_debug_forced: assert property (gh |-> eff_debug_o == 4'hF)
    else $error("debug traps not forced on");
  a_route_eff: assert property (lo[27] |-> eff_route_o == {3{!hx}})
    else $error("effective routing fields wrong");
  a_host_support: assert property (host_support_o == hx)
    else $error("host support does not follow its bit");
  a_ret_illegal: assert property (req_i.valid && req_i.op == HVT_OP_EXC_RETURN
    && req_i.target == HVT_GUEST_LEVEL && gh |=> resp_valid_o && resp_o.illegal_ret)
    else $error("guest return not illegal");
  a_tlbi_user_undef: assert property (req_i.valid && req_i.level == HVT_USER_LEVEL
    && req_i.op inside {[HVT_OP_TLBI64_LOCAL:HVT_OP_TLBI32]} |=> resp_o.undef && !resp_o.trap)
    else $error("user level invalidate not undefined");
  a_gen_ignores: assert property (req_i.valid && lo[27] |=> !resp_o.trap)
    else $error("trap raised while general trap set");
  a_vm_trap: assert property ((s_vm_req ##0 (lo[26] && !lo[27] && hyp_enabled_i))
    |-> !commit_ok_o ##1 s_trap18)
    else $error("guest control write not trapped");
endmodule : hvt_trap_ctrl_chk

bind hvt_trap_ctrl hvt_trap_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .hyp_enabled_i(hyp_enabled_i), .exc_to_guest_i(exc_to_guest_i), .req_i(req_i),
  .commit_ok_o(commit_ok_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
  .route_exc_to_hyp_o(route_exc_to_hyp_o), .eff_stage1_enable_o(eff_stage1_enable_o),
  .virq_enable_o(virq_enable_o), .eff_debug_o(eff_debug_o), .eff_route_o(eff_route_o),
  .host_support_o(host_support_o));

// ---- hvt_trap_ctrl_tb.sv ----
// self-checking bench for the hypervisor trap control block
`timescale 1ns/1ns
module testbench;
  import hvt_pkg::*;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        hyp_enabled_i = 1'b0;
  logic        exc_to_guest_i = 1'b0;
  hvt_req_s    req_i = '0;
  logic [31:0] rdata_o;
  logic        commit_ok_o, resp_valid_o, route_exc_to_hyp_o;
  logic        eff_stage1_enable_o, virq_enable_o, host_support_o;
  logic [3:0]  eff_debug_o;
  logic [2:0]  eff_route_o;
  hvt_resp_s   resp_o;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  hvt_trap_ctrl DUT (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .hyp_enabled_i(hyp_enabled_i), .exc_to_guest_i(exc_to_guest_i),
    .req_i(req_i), .commit_ok_o(commit_ok_o), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .route_exc_to_hyp_o(route_exc_to_hyp_o), .eff_stage1_enable_o(eff_stage1_enable_o),
    .virq_enable_o(virq_enable_o), .eff_debug_o(eff_debug_o), .eff_route_o(eff_route_o),
    .host_support_o(host_support_o));
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // helpers
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(negedge mclk_i);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o, e);
  endtask : rd
  // f holds the expected {trap, undef, illegal return}; the class is compared on traps only
  task op(input hvt_op_e o, input hvt_level_e lv, input logic g, input logic [2:0] f, input logic [5:0] ec);
    @(posedge mclk_i);
    req_i <= '{1'b1, o, lv, HVT_GUEST_LEVEL, g};
    @(negedge mclk_i);
    chk(commit_ok_o, f == 3'b000);
    @(posedge mclk_i);
    req_i.valid <= 1'b0;
    @(negedge mclk_i);
    chk(resp_valid_o, 1'b1);
    chk({resp_o.trap, resp_o.undef, resp_o.illegal_ret}, f);
    if (f[2]) chk(resp_o.exception_class, ec);
  endtask : op
  // context inputs change right after a rising edge, like every other stimulus
  task ctx(input logic h, input logic e);
    @(posedge mclk_i);
    hyp_enabled_i <= h;
    exc_to_guest_i <= e;
  endtask : ctx
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done;
    end
  end
  // ==========================================================
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(8'h00, 32'h0);
    chk(virq_enable_o, 1'b1);
    chk(route_exc_to_hyp_o, 1'b0);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h0);
    ctx(1'b1, 1'b0);
    wr(8'h00, 32'h0600_0000);
    op(HVT_OP_SYSREG_WR64, HVT_GUEST_LEVEL, 1'b0, 3'b100, 6'h18);
    rd(8'h0C, 32'h0);
    op(HVT_OP_COPROC_SINGLE, HVT_GUEST_LEVEL, 1'b1, 3'b100, 6'h03);
    op(HVT_OP_COPROC_DOUBLE, HVT_GUEST_LEVEL, 1'b1, 3'b100, 6'h04);
    for (int i = 3; i < 8; i++) op(hvt_op_e'(4'(i)), HVT_GUEST_LEVEL, 1'b0, 3'b100, 6'h18);
    op(HVT_OP_TLBI32, HVT_GUEST_LEVEL, 1'b1, 3'b100, 6'h03);
    op(HVT_OP_TLBI64_LOCAL, HVT_USER_LEVEL, 1'b0, 3'b010, 6'h00);
    rd(8'h10, 32'h0009_0000);
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h0);
    ctx(1'b0, 1'b0);
    op(HVT_OP_TLBI32, HVT_GUEST_LEVEL, 1'b1, 3'b000, 6'h00);
    op(HVT_OP_SYSREG_WR64, HVT_GUEST_LEVEL, 1'b0, 3'b000, 6'h00);
    chk(eff_stage1_enable_o, 1'b1);
    ctx(1'b1, 1'b0);
    wr(8'h00, 32'h0);
    op(HVT_OP_COPROC_SINGLE, HVT_GUEST_LEVEL, 1'b1, 3'b000, 6'h00);
    ctx(1'b1, 1'b1);
    wr(8'h00, 32'h0E00_0000);
    chk(route_exc_to_hyp_o, 1'b1);
    chk(eff_stage1_enable_o, 1'b0);
    chk(virq_enable_o, 1'b0);
    chk(eff_debug_o, 4'hF);
    chk(eff_route_o, 3'h7);
    rd(8'h0C, 32'h1);
    rd(8'h08, 32'h0);
    rd(8'h00, 32'h0E00_0000);
    op(HVT_OP_SYSREG_WR64, HVT_GUEST_LEVEL, 1'b0, 3'b000, 6'h00);
    op(HVT_OP_TLBI64_IS, HVT_GUEST_LEVEL, 1'b0, 3'b000, 6'h00);
    op(HVT_OP_EXC_RETURN, HVT_GUEST_LEVEL, 1'b0, 3'b001, 6'h00);
    wr(8'h04, 32'h4);
    chk(eff_route_o, 3'h0);
    chk(host_support_o, 1'b1);
    rd(8'h10, 32'h0000_0300);
    ctx(1'b0, 1'b1);
    op(HVT_OP_EXC_RETURN, HVT_GUEST_LEVEL, 1'b0, 3'b000, 6'h00);
    chk(virq_enable_o, 1'b1);
    chk(eff_stage1_enable_o, 1'b1);
    chk(route_exc_to_hyp_o, 1'b0);
    chk(eff_route_o, 3'h0);
    // a second reset in mid-run must clear the stored controls again
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(8'h00, 32'h0);
    chk(host_support_o, 1'b0);
    test_done;
  end
endmodule : testbench
